/* File: hdl/ivdsp_top.sv */
// input digital volume with auto-level handover, de-emphasis and bass boost
//
// How it works
// - auto level off: host gain codes drive left and right record channels
// - gain code in 0.375 dB steps, F1h +36 dB, E1h default, 00h mute
// - new manual gain applies at zero crossing or zero-cross timeout
// - codes written while both ADCs are off apply after ADC initialisation
// - each changed write restarts zero-cross counter; space such writes apart
// - writes equal to previous value are ignored, counter untouched
// - auto level start with differing codes uses left code for both
// - auto level begins within recovery wait plus zero-cross timeout
// - writes during auto level do not affect gain; applied after disable
// - de-emphasis select: 00 44.1k, 01 off, 10 48k, 11 32k
// - bass boost select: 00 off, 01 min, 10 mid, 11 max
// - boosted output clips at full scale instead of wrapping
// - zero-cross timeout codes give 128, 256, 512, 1024 sample periods
`timescale 1ns/100ps
`include "ivdsp_defs.svh"
module ivdsp_top (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic AUTO_LEVEL_ENABLE,
  input wire logic LEFT_ADC_POWER,
  input wire logic RIGHT_ADC_POWER,
  input wire logic [1:0] ZERO_CROSS_TIMEOUT,
  input wire logic [1:0] RECOVERY_WAIT_PERIOD,
  input wire logic [1:0] DEEMPHASIS_SELECT,
  input wire logic [1:0] BASS_BOOST_SELECT,
  input wire logic ADC_VALID,
  input wire ivdsp_pkg::ivdsp_stereo_t ADC_DATA,
  output logic REC_VALID,
  output ivdsp_pkg::ivdsp_stereo_t REC_DATA,
  input wire logic DAC_VALID,
  input wire ivdsp_pkg::ivdsp_stereo_t DAC_DATA,
  output logic PB_VALID,
  output ivdsp_pkg::ivdsp_stereo_t PB_DATA,
  output logic [7:0] LEFT_GAIN_APPLIED,
  output logic [7:0] RIGHT_GAIN_APPLIED,
  output logic AUTO_LEVEL_ACTIVE
);
  ivdsp_pkg::ivdsp_state_t st_ff, nxt_st;
  logic [7:0] pend_ff [2];
  logic [7:0] gain_ff [2];
  logic [7:0] nxt_gain [2];
  logic [10:0] zc_cnt_ff, nxt_zc_cnt;
  logic [10:0] cnt_ff, nxt_cnt;
  logic [1:0] prev_neg_ff;
  logic [1:0] done_ff, nxt_done;
  logic [7:0] rdata_ff;
  ivdsp_pkg::ivdsp_stereo_t rec_ff, pb_ff;
  logic rec_v_ff, pb_v_ff, active_ff;

  // ---- register port and write filtering ----
  wire wr_l = REG_WR && (REG_ADDR == `IVDSP_ADDR_IVL);
  wire wr_r = REG_WR && (REG_ADDR == `IVDSP_ADDR_IVR);
  wire chg_l = wr_l && (REG_WDATA != pend_ff[0]);
  wire chg_r = wr_r && (REG_WDATA != pend_ff[1]);
  wire [7:0] nxt_rdata = (REG_ADDR == `IVDSP_ADDR_IVL) ? pend_ff[0] :
                         (REG_ADDR == `IVDSP_ADDR_IVR) ? pend_ff[1] : 8'h00;

  // ---- sample timing ----
  wire powered = LEFT_ADC_POWER || RIGHT_ADC_POWER;
  wire [10:0] zc_period = `IVDSP_ZC_BASE << ZERO_CROSS_TIMEOUT;
  wire [10:0] wait_period = `IVDSP_ZC_BASE << RECOVERY_WAIT_PERIOD;
  // >= keeps a shortened timeout from letting the counter run past it
  wire tmo = ADC_VALID && (zc_cnt_ff >= zc_period - `IVDSP_CNT_ONE);
  wire [1:0] cur_neg = {ADC_DATA.r[15], ADC_DATA.l[15]};
  wire [1:0] zc = {2{ADC_VALID}} & (cur_neg ^ prev_neg_ff);
  wire enter_start = (st_ff == ivdsp_pkg::ST_ALC_WAIT) && (nxt_st == ivdsp_pkg::ST_ALC_START);
  wire zc_restart = chg_l || chg_r || enter_start;
  wire init_end = ADC_VALID && (cnt_ff == `IVDSP_INIT_SAMPLES - `IVDSP_CNT_ONE);
  wire wait_end = ADC_VALID && (cnt_ff >= wait_period - `IVDSP_CNT_ONE);

  always_comb begin
    nxt_zc_cnt = zc_cnt_ff;
    if (zc_restart || tmo) begin
      nxt_zc_cnt = 11'h000;
    end else if (ADC_VALID) begin
      nxt_zc_cnt = zc_cnt_ff + `IVDSP_CNT_ONE;
    end
  end

  // ---- control state machine ----
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = ADC_VALID ? cnt_ff + `IVDSP_CNT_ONE : cnt_ff;
    nxt_gain = gain_ff;
    nxt_done = done_ff;
    unique case (st_ff)
      ivdsp_pkg::ST_DOWN: begin
        nxt_cnt = 11'h000;
        if (powered) begin
          nxt_st = ivdsp_pkg::ST_INIT;
        end
      end
      ivdsp_pkg::ST_INIT: begin
        // held codes applied at init end
        if (init_end) begin
          nxt_gain = pend_ff;
          nxt_st = ivdsp_pkg::ST_MANUAL;
        end
      end
      ivdsp_pkg::ST_MANUAL: begin
        nxt_cnt = 11'h000;
        // manual apply at zero cross or timeout
        for (int c = 0; c < 2; c++) begin
          if (zc[c] || tmo) begin
            nxt_gain[c] = pend_ff[c];
          end
        end
        if (AUTO_LEVEL_ENABLE) begin
          nxt_st = ivdsp_pkg::ST_ALC_WAIT;
        end
      end
      ivdsp_pkg::ST_ALC_WAIT: begin
        if (wait_end) begin
          nxt_st = ivdsp_pkg::ST_ALC_START;
          nxt_done = 2'h0;
        end
      end
      ivdsp_pkg::ST_ALC_START: begin
        // both channels start from the left code
        for (int c = 0; c < 2; c++) begin
          if (zc[c] || tmo) begin
            nxt_gain[c] = pend_ff[0];
            nxt_done[c] = 1'b1;
          end
        end
        if (&nxt_done) begin
          nxt_st = ivdsp_pkg::ST_ALC_RUN;
        end
      end
      // gain left to the level loop; host writes only stored
      ivdsp_pkg::ST_ALC_RUN: begin
      end
    endcase
    if (st_ff != ivdsp_pkg::ST_DOWN && st_ff != ivdsp_pkg::ST_INIT && !AUTO_LEVEL_ENABLE) begin
      nxt_st = ivdsp_pkg::ST_MANUAL;
    end
    if (!powered) begin
      nxt_st = ivdsp_pkg::ST_DOWN;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      st_ff <= ivdsp_pkg::ST_DOWN;
      pend_ff <= '{`IVDSP_VOL_RST, `IVDSP_VOL_RST};
      gain_ff <= '{`IVDSP_VOL_RST, `IVDSP_VOL_RST};
      zc_cnt_ff <= 11'h000;
      cnt_ff <= 11'h000;
      prev_neg_ff <= 2'h0;
      done_ff <= 2'h0;
      rdata_ff <= 8'h00;
      active_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      if (wr_l) begin
        pend_ff[0] <= REG_WDATA;
      end
      if (wr_r) begin
        pend_ff[1] <= REG_WDATA;
      end
      gain_ff <= nxt_gain;
      zc_cnt_ff <= nxt_zc_cnt;
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
      rdata_ff <= nxt_rdata;
      active_ff <= (nxt_st == ivdsp_pkg::ST_ALC_RUN);
      if (ADC_VALID) begin
        prev_neg_ff <= cur_neg;
      end
    end
  end

  // ---- sample datapath, one pass per sample ----
  logic signed [15:0] adc_in [2];
  logic signed [15:0] rec_out [2];
  logic signed [15:0] dac_in [2];
  logic signed [15:0] pb_out [2];
  logic signed [15:0] x1_ff [2];
  logic signed [15:0] y1_ff [2];
  logic signed [15:0] lp_ff [2];
  logic signed [15:0] dem_y [2];
  assign adc_in = '{ADC_DATA.l, ADC_DATA.r};
  assign dac_in = '{DAC_DATA.l, DAC_DATA.r};

  wire signed [17:0] b0 = (DEEMPHASIS_SELECT == `IVDSP_DEM_48) ? `IVDSP_B0_48 :
                          (DEEMPHASIS_SELECT == `IVDSP_DEM_32) ? `IVDSP_B0_32 : `IVDSP_B0_441;
  wire signed [17:0] b1 = (DEEMPHASIS_SELECT == `IVDSP_DEM_48) ? `IVDSP_B1_48 :
                          (DEEMPHASIS_SELECT == `IVDSP_DEM_32) ? `IVDSP_B1_32 : `IVDSP_B1_441;
  wire signed [17:0] a1 = (DEEMPHASIS_SELECT == `IVDSP_DEM_48) ? `IVDSP_A1_48 :
                          (DEEMPHASIS_SELECT == `IVDSP_DEM_32) ? `IVDSP_A1_32 : `IVDSP_A1_441;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    ivdsp_gain u_gain (
      .code(gain_ff[c]),
      .din(adc_in[c]),
      .dout(rec_out[c])
    );
    wire signed [47:0] acc = 48'(b0 * dac_in[c]) + 48'(b1 * x1_ff[c]) + 48'(a1 * y1_ff[c]);
    assign dem_y[c] = (DEEMPHASIS_SELECT == `IVDSP_DEM_OFF) ? dac_in[c] :
                      ivdsp_pkg::ivdsp_sat(acc >>> `IVDSP_COEF_FRAC);
    // low shelf: a one-pole low pass added back at the chosen weight
    wire signed [16:0] diff = 17'(dem_y[c]) - 17'(lp_ff[c]);
    wire signed [15:0] nxt_lp = 16'(17'(lp_ff[c]) + (diff >>> `IVDSP_BASS_K));
    wire signed [17:0] lp_w = 18'(lp_ff[c]);
    wire signed [17:0] term = (BASS_BOOST_SELECT == `IVDSP_BST_MIN) ? (lp_w >>> 1) :
                              (BASS_BOOST_SELECT == `IVDSP_BST_MID) ? lp_w :
                              (BASS_BOOST_SELECT == `IVDSP_BST_MAX) ? (lp_w <<< 1) : 18'sh00000;
    assign pb_out[c] = ivdsp_pkg::ivdsp_sat(48'(dem_y[c]) + 48'(term));
    always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
        x1_ff[c] <= 16'sh0000;
        y1_ff[c] <= 16'sh0000;
        lp_ff[c] <= 16'sh0000;
      end else if (DAC_VALID) begin
        x1_ff[c] <= dac_in[c];
        y1_ff[c] <= dem_y[c];
        lp_ff[c] <= nxt_lp;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      rec_v_ff <= 1'b0;
      pb_v_ff <= 1'b0;
      rec_ff <= '0;
      pb_ff <= '0;
    end else begin
      rec_v_ff <= ADC_VALID;
      pb_v_ff <= DAC_VALID;
      if (ADC_VALID) begin
        rec_ff <= '{rec_out[0], rec_out[1]};
      end
      if (DAC_VALID) begin
        pb_ff <= '{pb_out[0], pb_out[1]};
      end
    end
  end

  assign REG_RDATA = rdata_ff;
  assign REC_VALID = rec_v_ff;
  assign REC_DATA = rec_ff;
  assign PB_VALID = pb_v_ff;
  assign PB_DATA = pb_ff;
  assign LEFT_GAIN_APPLIED = gain_ff[0];
  assign RIGHT_GAIN_APPLIED = gain_ff[1];
  assign AUTO_LEVEL_ACTIVE = active_ff;
  // ---- checks ----
  a_mute_code_out: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (ADC_VALID && gain_ff[1] == `IVDSP_VOL_MUTE) |=> (REC_DATA.r == 16'sh0000))
    else $error("muted right channel passed signal");
  a_manual_needs_zc: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (st_ff == ivdsp_pkg::ST_MANUAL && !zc[0] && !tmo) |=> $stable(gain_ff[0]))
    else $error("manual gain changed without zero cross or timeout");
  a_same_write_keep: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (wr_l && !chg_l && !chg_r && !enter_start && !ADC_VALID)
    |=> (zc_cnt_ff == $past(zc_cnt_ff)))
    else $error("equal write disturbed zero-cross counter");
  a_new_write_reset: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (chg_l || chg_r) |=> (zc_cnt_ff == 11'h000))
    else $error("changed write did not restart zero-cross counter");
  a_alc_gain_frozen: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (st_ff == ivdsp_pkg::ST_ALC_RUN && AUTO_LEVEL_ENABLE && powered)
    |=> ($stable(gain_ff[0]) && $stable(gain_ff[1])))
    else $error("host write moved gain during auto level");
  a_alc_left_start: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (st_ff == ivdsp_pkg::ST_ALC_START && tmo) |=> (gain_ff[1] == $past(pend_ff[0])))
    else $error("auto level start did not use left code");
  a_down_holds_gain: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (st_ff == ivdsp_pkg::ST_DOWN) |=> ($stable(gain_ff[0]) && $stable(gain_ff[1])))
    else $error("gain applied while converters powered down");
  a_dem_off_pass: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (DAC_VALID && DEEMPHASIS_SELECT == `IVDSP_DEM_OFF && BASS_BOOST_SELECT == `IVDSP_BST_OFF)
    |=> (PB_DATA == $past(DAC_DATA)))
    else $error("playback altered with filters off");
  a_wait_bounded: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (st_ff == ivdsp_pkg::ST_ALC_WAIT && RECOVERY_WAIT_PERIOD == 2'h0 && $stable(RECOVERY_WAIT_PERIOD))
    |-> (cnt_ff < `IVDSP_ZC_BASE))
    else $error("auto level wait overran recovery period");
endmodule : ivdsp_top

/* File: hdl/ivdsp_defs.svh */
// constants for the input volume and tone control block
`ifndef IVDSP_DEFS_SVH
`define IVDSP_DEFS_SVH
`define IVDSP_ADDR_IVL 8'h09
`define IVDSP_ADDR_IVR 8'h0c
`define IVDSP_VOL_RST 8'he1
`define IVDSP_VOL_MUTE 8'h00
`define IVDSP_CODE_MIN 8'h01
`define IVDSP_GAIN_SHIFT 23
`define IVDSP_ZC_BASE 11'h080
`define IVDSP_INIT_SAMPLES 11'h040
`define IVDSP_CNT_ONE 11'h001
`define IVDSP_DEM_441 2'h0
`define IVDSP_DEM_OFF 2'h1
`define IVDSP_DEM_48 2'h2
`define IVDSP_DEM_32 2'h3
`define IVDSP_BST_OFF 2'h0
`define IVDSP_BST_MIN 2'h1
`define IVDSP_BST_MID 2'h2
`define IVDSP_BST_MAX 2'h3
`define IVDSP_COEF_FRAC 14
`define IVDSP_B0_441 18'sh01b7b
`define IVDSP_B1_441 -18'sh003d2
`define IVDSP_A1_441 18'sh02857
`define IVDSP_B0_48 18'sh01aed
`define IVDSP_B1_48 -18'sh004db
`define IVDSP_A1_48 18'sh029ee
`define IVDSP_B0_32 18'sh01ddd
`define IVDSP_B1_32 18'sh0009c
`define IVDSP_A1_32 18'sh02186
`define IVDSP_BASS_K 6
`define IVDSP_SAT_HI 48'sh7fff
`define IVDSP_SAT_LO -48'sh8000
`endif

/* File: hdl/ivdsp_pkg.sv */
// types and saturation helper for the input volume and tone control block
`include "ivdsp_defs.svh"
package ivdsp_pkg;
  typedef struct packed {
    logic signed [15:0] l;
    logic signed [15:0] r;
  } ivdsp_stereo_t;

  typedef enum logic [2:0] {
    ST_DOWN, ST_INIT, ST_MANUAL, ST_ALC_WAIT, ST_ALC_START, ST_ALC_RUN
  } ivdsp_state_t;

  function automatic logic signed [15:0] ivdsp_sat(input logic signed [47:0] v);
    if (v > `IVDSP_SAT_HI) begin
      return 16'sh7fff;
    end else if (v < `IVDSP_SAT_LO) begin
      return -16'sh8000;
    end
    return v[15:0];
  endfunction : ivdsp_sat
endpackage : ivdsp_pkg

/* File: hdl/ivdsp_gain.sv */
// one channel of the 0.375 dB step input volume multiplier
`timescale 1ns/100ps
`include "ivdsp_defs.svh"
module ivdsp_gain (
  input wire logic [7:0] code,
  input wire logic signed [15:0] din,
  output logic signed [15:0] dout
);
  // 2^(k/16) approximations of 0.375 dB * k, scaled by 2^14
  localparam logic [15:0] MANT [16] = '{
    16'h4000, 16'h42d3, 16'h45c6, 16'h48db, 16'h4c11, 16'h4f6d, 16'h52ed, 16'h5696,
    16'h5a67, 16'h5e65, 16'h628e, 16'h66e8, 16'h6b71, 16'h702e, 16'h7522, 16'h7a4e
  };
  wire [7:0] idx = code - `IVDSP_CODE_MIN;
  wire signed [32:0] prod = din * $signed({1'b0, MANT[idx[3:0]]});
  wire signed [47:0] wide = {{15{prod[32]}}, prod};
  // every 16 codes double the gain; code 91h lands on unity
  wire signed [47:0] scaled = (wide <<< idx[7:4]) >>> `IVDSP_GAIN_SHIFT;
  wire is_mute = (code == `IVDSP_VOL_MUTE);
  assign dout = is_mute ? 16'sh0000 : ivdsp_pkg::ivdsp_sat(scaled);
endmodule : ivdsp_gain

/* File: testbench/ivdsp_host_model.sv */
// host model driving the register port and control levels
`timescale 1ns/100ps
module ivdsp_host_model (
  input wire logic clk,
  output logic wr,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata,
  output logic auto_level_enable,
  output logic pwr_l,
  output logic pwr_r,
  output logic [1:0] zto,
  output logic [1:0] rwp
);
  initial begin
    wr = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    auto_level_enable = 1'b0;
    pwr_l = 1'b0;
    pwr_r = 1'b0;
    zto = 2'h0;
    rwp = 2'h0;
  end
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    // stale data is not left on the bus
    wdata = ~d;
  endtask : write
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    d = rdata;
  endtask : read
  task automatic power(input logic l, input logic r);
    @(negedge clk);
    pwr_l = l;
    pwr_r = r;
  endtask : power
  task automatic set_timeout(input logic [1:0] c);
    @(negedge clk);
    if (!auto_level_enable) begin
      zto = c;
      rwp = c;
    end
  endtask : set_timeout
  task automatic set_alc(input logic en);
    @(negedge clk);
    auto_level_enable = en;
    if (!en) begin
      repeat (2100) @(negedge clk);
    end
  endtask : set_alc
endmodule : ivdsp_host_model

/* File: testbench/ivdsp_top_tb_top.sv */
// self-checking bench for the input volume and tone control block
`timescale 1ns/100ps
module ivdsp_top_tb_top;
  logic core_clk;
  logic rst_b;
  logic wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic auto_level_enable;
  logic pwr_l;
  logic pwr_r;
  logic [1:0] zto;
  logic [1:0] rwp;
  logic [1:0] dem;
  logic [1:0] bst;
  logic adc_valid;
  logic dac_valid;
  ivdsp_pkg::ivdsp_stereo_t adc_data;
  ivdsp_pkg::ivdsp_stereo_t dac_data;
  ivdsp_pkg::ivdsp_stereo_t rec_data;
  ivdsp_pkg::ivdsp_stereo_t pb_data;
  logic [7:0] gl;
  logic [7:0] gr;
  logic active;
  logic rec_valid;
  logic pb_valid;
  int failures;
  int total_checks;
  ivdsp_host_model i_host (.clk(core_clk), .wr(wr), .addr(addr), .wdata(wdata), .rdata(rdata),
    .auto_level_enable(auto_level_enable), .pwr_l(pwr_l), .pwr_r(pwr_r), .zto(zto), .rwp(rwp));
  ivdsp_top i_dut (.CORE_CLK(core_clk), .RST_B(rst_b), .REG_WR(wr), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .AUTO_LEVEL_ENABLE(auto_level_enable), .LEFT_ADC_POWER(pwr_l),
    .RIGHT_ADC_POWER(pwr_r), .ZERO_CROSS_TIMEOUT(zto), .RECOVERY_WAIT_PERIOD(rwp),
    .DEEMPHASIS_SELECT(dem), .BASS_BOOST_SELECT(bst), .ADC_VALID(adc_valid),
    .ADC_DATA(adc_data), .REC_VALID(rec_valid), .REC_DATA(rec_data), .DAC_VALID(dac_valid),
    .DAC_DATA(dac_data), .PB_VALID(pb_valid), .PB_DATA(pb_data), .LEFT_GAIN_APPLIED(gl),
    .RIGHT_GAIN_APPLIED(gr), .AUTO_LEVEL_ACTIVE(active));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic gains(input logic [7:0] el, input logic [7:0] er);
    check({8'h00, gl}, {8'h00, el}, "left gain");
    check({8'h00, gr}, {8'h00, er}, "right gain");
  endtask : gains
  task automatic adc(input int n, input logic [15:0] l, input logic [15:0] r);
    repeat (n) begin
      @(negedge core_clk);
      adc_valid = 1'b1;
      adc_data = {l, r};
      @(negedge core_clk);
      adc_valid = 1'b0;
    end
  endtask : adc
  task automatic dac(input int n, input logic [15:0] l, input logic [15:0] r);
    repeat (n) begin
      @(negedge core_clk);
      dac_valid = 1'b1;
      dac_data = {l, r};
      @(negedge core_clk);
      dac_valid = 1'b0;
    end
  endtask : dac
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  task automatic t_reset();
    logic [7:0] d;
    i_host.read(8'h09, d);
    check({8'h00, d}, 16'h00e1, "left code");
    i_host.read(8'h0c, d);
    check({8'h00, d}, 16'h00e1, "right code");
    i_host.read(8'h10, d);
    check({8'h00, d}, 16'h0000, "unmapped read");
    gains(8'he1, 8'he1);
  endtask : t_reset
  task automatic t_init();
    i_host.write(8'h0c, 8'hc6);
    i_host.power(1'b1, 1'b0);
    adc(60, 16'h0100, 16'h0100);
    gains(8'he1, 8'he1);
    adc(8, 16'h0100, 16'h0100);
    gains(8'he1, 8'hc6);
  endtask : t_init
  task automatic t_gain();
    i_host.write(8'h09, 8'h91);
    i_host.write(8'h0c, 8'h00);
    adc(130, 16'h0100, 16'h0100);
    gains(8'h91, 8'h00);
    adc(1, 16'h03e8, 16'h03e8);
    check(rec_data.l, 16'h03e8, "unity gain");
    check(rec_data.r, 16'h0000, "mute");
    check({15'h0000, rec_valid}, 16'h0001, "record strobe");
    @(negedge core_clk);
    check({15'h0000, rec_valid}, 16'h0000, "record strobe end");
    i_host.write(8'h09, 8'hf1);
    adc(130, 16'h03e8, 16'h03e8);
    check(rec_data.l, 16'h7fff, "saturation");
    i_host.write(8'h09, 8'h91);
    adc(3, 16'h0100, 16'h0100);
    gains(8'hf1, 8'h00);
    adc(1, 16'hff00, 16'h0100);
    gains(8'h91, 8'h00);
  endtask : t_gain
  task automatic t_count();
    // use up the pending sign change so only the timeout can apply codes
    adc(1, 16'h0100, 16'h0100);
    i_host.write(8'h09, 8'h40);
    adc(100, 16'h0100, 16'h0100);
    gains(8'h91, 8'h00);
    i_host.write(8'h09, 8'h40);
    adc(40, 16'h0100, 16'h0100);
    gains(8'h40, 8'h00);
    i_host.write(8'h09, 8'h50);
    adc(100, 16'h0100, 16'h0100);
    i_host.write(8'h09, 8'h60);
    adc(40, 16'h0100, 16'h0100);
    gains(8'h40, 8'h00);
    adc(100, 16'h0100, 16'h0100);
    gains(8'h60, 8'h00);
    i_host.set_timeout(2'h1);
    i_host.write(8'h09, 8'h70);
    adc(200, 16'h0100, 16'h0100);
    gains(8'h60, 8'h00);
    adc(60, 16'h0100, 16'h0100);
    gains(8'h70, 8'h00);
    i_host.set_timeout(2'h2);
    i_host.write(8'h09, 8'h72);
    adc(500, 16'h0100, 16'h0100);
    gains(8'h70, 8'h00);
    adc(20, 16'h0100, 16'h0100);
    gains(8'h72, 8'h00);
    i_host.set_timeout(2'h3);
    i_host.write(8'h09, 8'h73);
    adc(1000, 16'h0100, 16'h0100);
    gains(8'h72, 8'h00);
    adc(30, 16'h0100, 16'h0100);
    gains(8'h73, 8'h00);
    i_host.set_timeout(2'h0);
  endtask : t_count
  task automatic t_alc();
    int i;
    i_host.write(8'h09, 8'he1);
    i_host.write(8'h0c, 8'hc6);
    adc(130, 16'h0100, 16'h0100);
    gains(8'he1, 8'hc6);
    i_host.set_alc(1'b1);
    for (i = 0; i < 270 && active !== 1'b1; i++) begin
      adc(1, 16'h0100, 16'h0100);
    end
    check({15'h0000, active}, 16'h0001, "auto start");
    if (active !== 1'b1) begin
      summarize();
    end
    gains(8'he1, 8'he1);
    i_host.write(8'h09, 8'h91);
    i_host.write(8'h0c, 8'h91);
    adc(150, 16'h0100, 16'h0100);
    gains(8'he1, 8'he1);
    i_host.set_alc(1'b0);
    adc(130, 16'h0100, 16'h0100);
    gains(8'h91, 8'h91);
  endtask : t_alc
  task automatic t_play();
    int k;
    i_host.write(8'h09, 8'h91);
    dac(1, 16'h04d2, 16'hef1f);
    check(pb_data.l, 16'h04d2, "flat left");
    check(pb_data.r, 16'hef1f, "flat right");
    check({15'h0000, pb_valid}, 16'h0001, "playback strobe");
    @(negedge core_clk);
    check({15'h0000, pb_valid}, 16'h0000, "playback strobe end");
    for (k = 0; k < 4; k++) begin
      if (k != 1) begin
        dem = k[1:0];
        dac(50, 16'h0000, 16'h0000);
        dac(1, 16'h4000, 16'h4000);
        check({15'h0000, pb_data.l === 16'h4000}, 16'h0000, "filter on");
      end
    end
    dem = 2'h1;
    for (k = 0; k < 4; k++) begin
      bst = k[1:0];
      dac(600, 16'h7530, 16'h7530);
      check(pb_data.l, k == 0 ? 16'h7530 : 16'h7fff, "boost high");
      dac(600, 16'h8ad0, 16'h8ad0);
      check(pb_data.r, k == 0 ? 16'h8ad0 : 16'h8000, "boost low");
    end
  endtask : t_play
  initial begin
    failures = 0;
    total_checks = 0;
    rst_b = 1'b0;
    dem = 2'h1;
    bst = 2'h0;
    adc_valid = 1'b0;
    dac_valid = 1'b0;
    adc_data = '0;
    dac_data = '0;
    repeat (20) @(negedge core_clk);
    rst_b = 1'b1;
    t_reset();
    t_init();
    t_gain();
    t_count();
    t_alc();
    t_play();
    summarize();
  end
endmodule : ivdsp_top_tb_top
